/* hw/dag_params.svh */
// Constants for the three-dimensional DMA address generator.
// Assumes inclusion by the design module only.
`ifndef DAG_PARAMS_SVH
`define DAG_PARAMS_SVH
// Register offsets on the plain register port
`define DAG_OFS_OFFSET0 4'h0
`define DAG_OFS_OFFSET1 4'h1
`define DAG_OFS_OFFSET2 4'h2
`define DAG_OFS_OFFSET3 4'h3
`define DAG_OFS_STATUS 4'h4
`define DAG_OFS_CONFIG 4'h5
`define DAG_OFS_COUNTER 4'h6
`define DAG_OFS_START 4'h7
`define DAG_OFS_ADDR 4'h8
// Config register fields
`define DAG_CFG_MODE_LSB 0
`define DAG_CFG_3D_BIT 6
`define DAG_CFG_CHAN_LSB 7
// Status register fields
`define DAG_STS_ACT_BIT 8
`define DAG_STS_CH_LSB 9
// Reset values
`define DAG_RST_WORD 24'h000000
`define DAG_RST_CH 3'h0
`endif

/* hw/dag_pkg.sv */
// Types for the three-dimensional DMA address generator.
// Assumes dag_params.svh is on the include path.
package dag_pkg;
  // Per-side address generation kind
  typedef enum logic [1:0] {
    DAG_KIND_FIX = 2'h0,
    DAG_KIND_INC = 2'h1,
    DAG_KIND_2D = 2'h2,
    DAG_KIND_3D = 2'h3
  } dag_kind_type;
  // Counter modes A..E
  typedef enum logic [2:0] {
    DAG_CNT_A = 3'h0,
    DAG_CNT_B = 3'h1,
    DAG_CNT_C = 3'h2,
    DAG_CNT_D = 3'h3,
    DAG_CNT_E = 3'h4
  } dag_cnt_type;
  // Transfer sequencer
  typedef enum logic [1:0] {
    DAG_ST_IDLE = 2'b01,
    DAG_ST_RUN = 2'b10
  } dag_state_type;
endpackage

/* hw/dag_engine.sv */
// Address generator of one DMA transfer with offset and status registers.
// Assumes a one-cycle register port and a one-cycle access request input.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "dag_params.svh"
module dag_engine
  import dag_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [23:0] reg_rdata,
  input wire logic access_req,
  output logic [23:0] src_addr,
  output logic [23:0] dst_addr,
  output logic access_valid,
  output logic busy
);
  default clocking dag_cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [23:0] offset_reg_q [4];
  logic [23:0] offset_reg_d [4];
  logic [9:0] cfg_q, cfg_d;
  logic [23:0] transfer_counter_q, transfer_counter_d;
  logic [23:0] src_base_q, src_base_d;
  logic [23:0] rdata_q, rdata_d;
  // Status fields
  logic transfer_active_flag;
  logic [2:0] active_channel_code;
  logic [23:0] dma_status_reg;
  // Transfer state
  dag_state_type state_q, state_d;
  dag_kind_type skind_q, skind_d, dkind_q, dkind_d;
  logic [1:0] soff_q, soff_d, doff_q, doff_d;
  dag_cnt_type cmode_q, cmode_d;
  logic [23:0] sa_q, sa_d, da_q, da_d;
  logic [11:0] lo_q, lo_d, mid_q, mid_d, hi_q, hi_d;
  logic [11:0] lo_len_q, lo_len_d, mid_len_q, mid_len_d;
  logic [2:0] ch_q, ch_d;
  logic valid_q, valid_d;
  ////////////////////////////////////////////////////////////////////////
  // Configuration decode
  logic [5:0] address_mode_field;
  logic three_dim_enable;
  dag_kind_type dec_s, dec_d, upper_kind;
  logic [1:0] dec_soff, dec_doff, upper_off;
  dag_cnt_type dec_cnt;
  logic [11:0] dec_hi, dec_mid, dec_lo;
  // Decode one three-bit address-mode code into its address generation kind
  function automatic dag_kind_type kind_of(input logic [2:0] code, input logic td);
    return (code == 3'h4) ? DAG_KIND_FIX : (code == 3'h5) ? DAG_KIND_INC :
           (code[2] && td) ? DAG_KIND_3D : DAG_KIND_2D;
  endfunction

  // Kind, offset and counter selection from the mode field
  always_comb begin
    address_mode_field = cfg_q[`DAG_CFG_MODE_LSB +: 6];
    three_dim_enable = cfg_q[`DAG_CFG_3D_BIT];
    upper_kind = kind_of(address_mode_field[5:3], three_dim_enable);
    upper_off = address_mode_field[5] ? {address_mode_field[3], 1'b0} : address_mode_field[4:3];
    dec_s = DAG_KIND_FIX;
    dec_d = DAG_KIND_FIX;
    dec_soff = 2'h0;
    dec_doff = 2'h0;
    dec_cnt = DAG_CNT_A;
    dec_hi = 12'h000;
    dec_mid = 12'h000;
    dec_lo = 12'h000;
    if (three_dim_enable) begin
      if (!address_mode_field[2]) begin
        dec_s = DAG_KIND_3D;
        dec_soff = 2'h0;
        dec_d = upper_kind;
        dec_doff = upper_off;
      end else begin
        dec_d = DAG_KIND_3D;
        dec_doff = 2'h2;
        dec_s = upper_kind;
        dec_soff = upper_off;
      end
      // Section boundaries of the counter
      unique case (address_mode_field[1:0])
        2'h0: begin
          dec_cnt = DAG_CNT_C;
          dec_hi = transfer_counter_q[23:12];
          dec_mid = {6'h00, transfer_counter_q[11:6]};
          dec_lo = {6'h00, transfer_counter_q[5:0]};
        end
        2'h1: begin
          dec_cnt = DAG_CNT_D;
          dec_hi = {6'h00, transfer_counter_q[23:18]};
          dec_mid = transfer_counter_q[17:6];
          dec_lo = {6'h00, transfer_counter_q[5:0]};
        end
        default: begin
          dec_cnt = DAG_CNT_E;
          dec_hi = {6'h00, transfer_counter_q[23:18]};
          dec_mid = {6'h00, transfer_counter_q[17:12]};
          dec_lo = transfer_counter_q[11:0];
        end
      endcase
    end else begin
      dec_d = kind_of(address_mode_field[5:3], 1'b0);
      dec_s = kind_of(address_mode_field[2:0], 1'b0);
      dec_doff = address_mode_field[4:3];
      dec_soff = address_mode_field[1:0];
      // Any 2D side forces the split counter
      if (dec_d == DAG_KIND_2D || dec_s == DAG_KIND_2D) begin
        dec_cnt = DAG_CNT_B;
        dec_hi = transfer_counter_q[23:12];
        dec_lo = transfer_counter_q[11:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port and status
  always_comb begin
    transfer_active_flag = (state_q == DAG_ST_RUN);
    active_channel_code = transfer_active_flag ? ch_q : `DAG_RST_CH;
    dma_status_reg = `DAG_RST_WORD;
    dma_status_reg[`DAG_STS_ACT_BIT] = transfer_active_flag;
    dma_status_reg[`DAG_STS_CH_LSB +: 3] = active_channel_code;
    cfg_d = cfg_q;
    transfer_counter_d = transfer_counter_q;
    src_base_d = src_base_q;
    for (int i = 0; i < 4; i++) begin
      offset_reg_d[i] = offset_reg_q[i];
    end
    if (reg_wr) begin
      unique case (reg_addr)
        `DAG_OFS_OFFSET0, `DAG_OFS_OFFSET1, `DAG_OFS_OFFSET2, `DAG_OFS_OFFSET3:
          offset_reg_d[reg_addr[1:0]] = reg_wdata;
        `DAG_OFS_CONFIG: cfg_d = reg_wdata[9:0];
        `DAG_OFS_COUNTER: transfer_counter_d = reg_wdata;
        `DAG_OFS_ADDR: src_base_d = reg_wdata;
        default: ;
      endcase
    end
    rdata_d = `DAG_RST_WORD;
    if (reg_rd) begin
      unique case (reg_addr)
        `DAG_OFS_OFFSET0, `DAG_OFS_OFFSET1, `DAG_OFS_OFFSET2, `DAG_OFS_OFFSET3:
          rdata_d = offset_reg_q[reg_addr[1:0]];
        `DAG_OFS_STATUS: rdata_d = dma_status_reg;
        `DAG_OFS_CONFIG: rdata_d = {14'h0000, cfg_q};
        `DAG_OFS_COUNTER: rdata_d = transfer_counter_q;
        `DAG_OFS_ADDR: rdata_d = sa_q;
        default: rdata_d = `DAG_RST_WORD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address sequencer
  logic [23:0] s_step, d_step;
  logic lo_end, mid_end, hi_end, start;
  // Step for one side given the wrap level reached
  function automatic logic [23:0] step_of(input dag_kind_type k, input logic [1:0] o,
                                          input logic lw, input logic mw, input logic [23:0] offs [4]);
    logic [23:0] s;
    s = 24'h000001;
    unique case (k)
      DAG_KIND_FIX: s = 24'h000000;
      DAG_KIND_INC: s = 24'h000001;
      DAG_KIND_2D: s = lw ? offs[o] : 24'h000001;
      DAG_KIND_3D: s = mw ? offs[{o[1], 1'b1}] : (lw ? offs[o] : 24'h000001);
    endcase
    return s;
  endfunction

  always_comb begin
    start = reg_wr && reg_addr == `DAG_OFS_START && state_q == DAG_ST_IDLE;
    lo_end = (lo_q == 12'h000);
    mid_end = (cmode_q == DAG_CNT_C || cmode_q == DAG_CNT_D || cmode_q == DAG_CNT_E) ? lo_end && mid_q == 12'h000 : lo_end;
    hi_end = mid_end && hi_q == 12'h000;
    s_step = step_of(skind_q, soff_q, lo_end, mid_end && cmode_q != DAG_CNT_B, offset_reg_q);
    d_step = step_of(dkind_q, doff_q, lo_end, mid_end && cmode_q != DAG_CNT_B, offset_reg_q);
    state_d = state_q;
    skind_d = skind_q;
    dkind_d = dkind_q;
    soff_d = soff_q;
    doff_d = doff_q;
    cmode_d = cmode_q;
    sa_d = sa_q;
    da_d = da_q;
    lo_d = lo_q;
    mid_d = mid_q;
    hi_d = hi_q;
    lo_len_d = lo_len_q;
    mid_len_d = mid_len_q;
    ch_d = ch_q;
    valid_d = 1'b0;
    unique case (state_q)
      DAG_ST_IDLE: begin
        if (start) begin
          state_d = DAG_ST_RUN;
          skind_d = dec_s;
          dkind_d = dec_d;
          soff_d = dec_soff;
          doff_d = dec_doff;
          cmode_d = dec_cnt;
          sa_d = src_base_q;
          da_d = reg_wdata;
          ch_d = cfg_q[`DAG_CFG_CHAN_LSB +: 3];
          lo_d = (dec_cnt == DAG_CNT_A) ? transfer_counter_q[11:0] : dec_lo;
          hi_d = (dec_cnt == DAG_CNT_A) ? transfer_counter_q[23:12] : dec_hi;
          mid_d = dec_mid;
          lo_len_d = (dec_cnt == DAG_CNT_A) ? 12'hfff : dec_lo;
          mid_len_d = dec_mid;
        end
      end
      DAG_ST_RUN: begin
        if (access_req) begin
          valid_d = 1'b1;
          sa_d = sa_q + s_step;
          da_d = da_q + d_step;
          if (hi_end) begin
            state_d = DAG_ST_IDLE;
          end else if (!lo_end) begin
            lo_d = lo_q - 12'h001;
          end else begin
            lo_d = lo_len_q;
            if (mid_end) begin
              mid_d = mid_len_q;
              hi_d = hi_q - 12'h001;
            end else begin
              mid_d = mid_q - 12'h001;
            end
          end
        end
      end
      default: state_d = DAG_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        offset_reg_q[i] <= `DAG_RST_WORD;
      end
      cfg_q <= 10'h000;
      transfer_counter_q <= `DAG_RST_WORD;
      src_base_q <= `DAG_RST_WORD;
      rdata_q <= `DAG_RST_WORD;
      state_q <= DAG_ST_IDLE;
      skind_q <= DAG_KIND_FIX;
      dkind_q <= DAG_KIND_FIX;
      soff_q <= 2'h0;
      doff_q <= 2'h0;
      cmode_q <= DAG_CNT_A;
      sa_q <= `DAG_RST_WORD;
      da_q <= `DAG_RST_WORD;
      lo_q <= 12'h000;
      mid_q <= 12'h000;
      hi_q <= 12'h000;
      lo_len_q <= 12'h000;
      mid_len_q <= 12'h000;
      ch_q <= `DAG_RST_CH;
      valid_q <= 1'b0;
    end else begin
      offset_reg_q <= offset_reg_d;
      cfg_q <= cfg_d;
      transfer_counter_q <= transfer_counter_d;
      src_base_q <= src_base_d;
      rdata_q <= rdata_d;
      state_q <= state_d;
      skind_q <= skind_d;
      dkind_q <= dkind_d;
      soff_q <= soff_d;
      doff_q <= doff_d;
      cmode_q <= cmode_d;
      sa_q <= sa_d;
      da_q <= da_d;
      lo_q <= lo_d;
      mid_q <= mid_d;
      hi_q <= hi_d;
      lo_len_q <= lo_len_d;
      mid_len_q <= mid_len_d;
      ch_q <= ch_d;
      valid_q <= valid_d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = rdata_q;
  assign src_addr = sa_q;
  assign dst_addr = da_q;
  assign access_valid = valid_q;
  assign busy = state_q[1]; // Run bit of the one-hot state

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_status_reserved_zero: assert property (reg_rd && reg_addr == `DAG_OFS_STATUS
    |=> reg_rdata[23:12] == 12'h000) else $error("status reserved bits not zero");
  a_status_active_flag: assert property (reg_rd && reg_addr == `DAG_OFS_STATUS
    |=> reg_rdata[8] == $past(state_q == DAG_ST_RUN)) else $error("active flag mismatch");
  a_fixed_addr_hold: assert property (state_q == DAG_ST_RUN && skind_q == DAG_KIND_FIX && access_req
    |=> src_addr == $past(sa_q)) else $error("fixed source address moved");
  a_inc_addr_step: assert property (state_q == DAG_ST_RUN && dkind_q == DAG_KIND_INC && access_req
    |=> dst_addr == $past(da_q) + 24'h000001) else $error("increment step wrong");
  a_side_select_3d: assert property (start && cfg_q[6]
    |=> (cfg_q[2] ? dkind_q : skind_q) == DAG_KIND_3D) else $error("3D side not selected");
  a_mixed_mode_b: assert property (start && !cfg_q[6] && (!cfg_q[5] || !cfg_q[2])
    |=> cmode_q == DAG_CNT_B) else $error("2D side not run as mode B");
  a_channel_latch: assert property (start |=> ##1 (reg_rd && reg_addr == `DAG_OFS_STATUS)
    |=> reg_rdata[11:9] == $past(ch_q, 2)) else $error("channel code wrong");
  a_config_frozen: assert property (state_q == DAG_ST_RUN && $stable(state_q)
    |-> $stable(cmode_q) && $stable(soff_q)) else $error("config changed mid transfer");
endmodule

/* verif/dag_dma_side.sv */
// Model of the DMA side that issues one access request per slot.
// Assumes a design that takes access_req only while busy is high.
`timescale 1ns/1ns
module dag_dma_side (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic busy,
  input wire logic go,
  input wire logic [3:0] gap,
  output logic access_req
);
  logic [3:0] wait_q;
  ////////////////////////////////////////////////////////////////
  // Request while a transfer runs, pausing gap cycles after each
  always @(posedge clock) begin
    if (!rst_n || !go) begin
      access_req <= 1'b0;
      wait_q <= 4'h0;
    end else if (access_req && gap != 4'h0) begin
      access_req <= 1'b0;
      wait_q <= gap - 4'h1;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else begin
      access_req <= busy; // May linger one idle cycle, which must be ignored
    end
  end
endmodule

/* verif/test_dag_3d_address_generation.sv */
// Testbench for the three-dimensional DMA address generator.
// Assumes dag_pkg, dag_engine and dag_dma_side are compiled first.
`timescale 1ns/1ns
module test_dag_3d_address_generation;
  import dag_pkg::*;
  logic clock, rst_n, reg_wr, reg_rd, go, access_req, access_valid, busy;
  logic [3:0] reg_addr, gap;
  logic [23:0] reg_wdata, reg_rdata, src_addr, dst_addr, rd;
  logic [23:0] offs [4];
  int kd [2];
  int oa [2];
  int ob [2];
  int lo_w, mid_w, mismatches, n_compared;
  ////////////////////////////////////////////////////////////////
  dag_engine u_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .access_req(access_req), .src_addr(src_addr), .dst_addr(dst_addr),
    .access_valid(access_valid), .busy(busy));
  dag_dma_side u_side (.clock(clock), .rst_n(rst_n), .busy(busy), .go(go), .gap(gap), .access_req(access_req));
  // Clock at 50 MHz
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////
  // Comparison, bus cycles and verdict
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [23:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [23:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Reference decode: kind 0 fixed, 1 increment, 2 two-dim, 3 three-dim
  function automatic void dec_side(input int s, input logic [2:0] c);
    kd[s] = c < 4 ? 2 : c == 4 ? 0 : c == 5 ? 1 : 3;
    oa[s] = c < 4 ? int'(c) : c == 6 ? 0 : 2;
    ob[s] = oa[s] + 1;
  endfunction
  function automatic void decode(input logic [9:0] cfg);
    if (cfg[6]) begin
      dec_side(cfg[2] ? 0 : 1, cfg[5:3]);
      dec_side(cfg[2] ? 1 : 0, cfg[2] ? 3'h7 : 3'h6);
      lo_w = cfg[1:0] == 2'h2 ? 12 : 6;
      mid_w = cfg[1:0] == 2'h1 ? 12 : 6;
    end else begin
      dec_side(1, cfg[5:3]);
      dec_side(0, cfg[2:0]);
      lo_w = 12;
      mid_w = 0;
    end
  endfunction
  function automatic logic [23:0] step(input int s, input logic [23:0] a, input logic lw, input logic mw);
    case (kd[s])
      0: return a;
      1: return a + 24'h1;
      2: return lw ? a + offs[oa[s]] : a + 24'h1;
      default: return mw ? a + offs[ob[s]] : lw ? a + offs[oa[s]] : a + 24'h1;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////
  // Offset and status registers, unmapped place
  task automatic test_regs();
    logic [23:0] v;
    reg_read(4'h4, v);
    check("status_reset", v, 24'h0);
    for (int i = 0; i < 4; i++) begin
      offs[i] = 24'h10 << (4 * i);
      reg_write(i[3:0], offs[i]);
    end
    for (int i = 0; i < 4; i++) begin
      reg_read(i[3:0], v);
      check("offset", v, offs[i]);
    end
    reg_write(4'h4, 24'hffffff);
    reg_read(4'h4, v);
    check("status_ro", v, 24'h0);
    reg_read(4'hf, v);
    check("unmapped", v, 24'h0);
  endtask
  // One transfer, every address compared against the reference walk
  task automatic run_xfer(input logic [9:0] cfg, input logic [23:0] cnt, input logic [23:0] src,
      input logic [23:0] dst, input logic [3:0] g, input logic poke);
    logic [23:0] ea [2];
    int lo, mid, hi, lo0, mid0, lo_rl, w;
    logic lw, mw, done;
    decode(cfg);
    ea[0] = src;
    ea[1] = dst;
    lo0 = int'(cnt) & ((1 << lo_w) - 1);
    mid0 = (int'(cnt) >> lo_w) & ((1 << mid_w) - 1);
    hi = int'(cnt) >> (lo_w + mid_w);
    lo = lo0;
    mid = mid0;
    lo_rl = (!cfg[6] && kd[0] != 2 && kd[1] != 2) ? 4095 : lo0;
    reg_write(4'h8, src);
    reg_write(4'h5, {14'h0, cfg});
    reg_write(4'h6, cnt);
    reg_write(4'h7, dst);
    @(negedge clock);
    check("busy", {23'h0, busy}, 24'h1);
    reg_read(4'h4, rd);
    check("status_run", rd, {12'h0, cfg[9:7], 1'b1, 8'h0});
    if (poke) begin
      reg_write(4'h5, 24'h0);
      reg_write(4'h7, 24'h123456);
    end
    @(posedge clock);
    gap <= g;
    go <= 1'b1;
    done = 1'b0;
    while (!done) begin
      w = 0;
      do begin
        @(negedge clock);
        w++;
      end while (access_valid !== 1'b1 && w < 40);
      check("access_valid", {23'h0, access_valid}, 24'h1);
      lw = lo == 0;
      mw = lw && mid == 0;
      done = (mw && hi == 0) || access_valid !== 1'b1;
      ea[0] = step(0, ea[0], lw, mw);
      ea[1] = step(1, ea[1], lw, mw);
      check("src_addr", src_addr, ea[0]);
      check("dst_addr", dst_addr, ea[1]);
      if (!lw) begin
        lo--;
      end else begin
        lo = lo_rl;
        if (!mw) begin
          mid--;
        end else begin
          mid = mid0;
          hi--;
        end
      end
    end
    repeat (3) @(negedge clock);
    go <= 1'b0;
    check("busy_end", {23'h0, busy}, 24'h0);
    check("src_idle", src_addr, ea[0]);
    reg_read(4'h4, rd);
    check("status_end", rd, 24'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  // Watchdog against a hung transfer
  initial begin
    repeat (8000) @(posedge clock);
    mismatches++;
    print_verdict();
  end
  // Main sequence; counter codes stay off the reserved value
  initial begin
    mismatches = 0;
    n_compared = 0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 24'h0;
    go = 1'b0;
    gap = 4'h0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    test_regs();
    run_xfer(10'h0ac, 24'h001002, 24'h000100, 24'h002000, 4'h0, 1'b0);
    run_xfer(10'h115, 24'h001002, 24'h000300, 24'h004000, 4'h2, 1'b0);
    run_xfer(10'h1c0, 24'h001041, 24'h000500, 24'h006000, 4'h1, 1'b0);
    run_xfer(10'h2fd, 24'h000042, 24'h000700, 24'h008000, 4'h0, 1'b0);
    run_xfer(10'h24e, 24'h040001, 24'h000900, 24'h00a000, 4'h0, 1'b1);
    print_verdict();
  end
endmodule
